/* core/boot_b_pkg.sv */
`default_nettype none
package boot_b_pkg;
  // register byte address on the system map
  localparam logic [31:0] BASE_SIZE_ADDR = 32'hfef80058;
  // big-endian bit numbering of the register: bit 0 is msb (index 31)
  localparam int BASE_MSB = 31;
  localparam int BASE_LSB = 20;
  localparam int WIDE_BIT = 19;
  localparam int SIZE_MSB = 18;
  localparam int SIZE_LSB = 16;
  localparam int VEC_BIT = 2;
  localparam int EN_BIT = 1;
  localparam int WE_BIT = 0;
  // reset values
  localparam logic [11:0] BASE_RESET = 12'hff4;
  localparam logic [2:0] SIZE_RESET = 3'h0;
  // size codes
  localparam logic [2:0] SIZE_MAX = 3'h6;
  // reset-vector region: top megabyte
  localparam logic [11:0] VEC_REGION = 12'hfff;
  // access size codes on the request port
  localparam logic [2:0] XFER_BYTE = 3'h0;
  localparam logic [2:0] XFER_WORD = 3'h2;
endpackage
`default_nettype wire

/* core/base_decode.sv */
`default_nettype none
// compares address bits 31..20 against the base under a size mask
module base_decode (
  // compare inputs
  input wire logic [11:0] addrHigh,
  input wire logic [11:0] baseField,
  input wire logic [2:0] sizeCode,
  // result
  output logic hit
);
  logic [11:0] careMask;
  // reserved code falls back to the largest size
  always_comb begin
    careMask = 12'hfff;
    if (sizeCode == 3'h7) begin
      careMask = 12'hfff << boot_b_pkg::SIZE_MAX;
    end else begin
      careMask = 12'hfff << sizeCode;
    end
    hit = ((addrHigh ^ baseField) & careMask) == 12'h000;
  end
endmodule
`default_nettype wire

/* core/boot_rom_block_b_decoder.sv */
`default_nettype none
//Contract
//RULE1: base bits 0..11 compare with bus address bits 0..11, bit 0 msb.
//RULE2: base bits inside the block are ignored for larger sizes.
//RULE3: base loads ff4 on power-up and local bus reset.
//RULE4: boot vector set maps first megabyte at fff00000 too.
//RULE5: vector region goes to B if its bit set, A if only A's.
//RULE6: wide bit clear means 8-bit block, set means 32-bit.
//RULE7: wide bit is inverse of width strap at power-up; read-only.
//RULE8: size codes 0..6 select 1 to 64 megabytes; 7 reserved.
//RULE9: boot vector bit is inverse of vector strap at power-up.
//RULE10: programmed window answers only while access enable set.
//RULE11: storage writes happen only while write enable set.
//RULE12: narrow takes bytes, wide aligned words; else no answer. Code checks writes only; reads of any size or alignment get termAck.
//RULE13: software keeps the block clear of every other slave.
//RULE14: reserved size code decodes as the largest size.
module boot_rom_block_b_decoder (
  // clock and resets
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic powerUp,
  input wire logic localReset,
  // straps
  input wire logic strapWidthPin,
  input wire logic strapVectorPin,
  // block A vector bit from the sibling register
  input wire logic blockABootVector,
  // register port
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  // processor bus request
  input wire logic busValid,
  input wire logic busWrite,
  input wire logic [31:0] busAddr,
  input wire logic [2:0] busSize,
  // decode answers
  output logic blockSelect,
  output logic termAck,
  output logic storeStrobe,
  output logic wideMode
);
  logic [11:0] baseR;
  logic [2:0] sizeR;
  logic wideR;
  logic vecR;
  logic enR;
  logic weR;
  logic [31:0] rdataR;
  logic selR;
  logic ackR;
  logic storeR;
  logic strapPendingR;
  logic winHit;
  logic vecHit;
  logic hitAny;
  logic writeOk;
  logic [31:0] regView;

  // register decode shared by write, strap and read paths
  function automatic logic isRegAddr(input logic [31:0] addr);
    return addr == boot_b_pkg::BASE_SIZE_ADDR;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // control register
  // software fields; base and size reset on either reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      baseR <= boot_b_pkg::BASE_RESET; // [RULE3]
      sizeR <= boot_b_pkg::SIZE_RESET;
      enR <= 1'b0;
      weR <= 1'b0;
    end else if (powerUp || localReset) begin
      baseR <= boot_b_pkg::BASE_RESET; // [RULE3]
      sizeR <= boot_b_pkg::SIZE_RESET;
      enR <= 1'b0;
      weR <= 1'b0;
    end else if (regWrite && isRegAddr(regAddr)) begin
      baseR <= regWdata[boot_b_pkg::BASE_MSB:boot_b_pkg::BASE_LSB];
      sizeR <= regWdata[boot_b_pkg::SIZE_MSB:boot_b_pkg::SIZE_LSB];
      enR <= regWdata[boot_b_pkg::EN_BIT];
      weR <= regWdata[boot_b_pkg::WE_BIT];
    end
  end

  // straps are sampled in the cycle after reset release, never under async reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strapPendingR <= 1'b1;
      wideR <= 1'b0;
      vecR <= 1'b0;
    end else if (powerUp) begin
      strapPendingR <= 1'b1;
    end else if (strapPendingR) begin
      strapPendingR <= 1'b0;
      wideR <= ~strapWidthPin; // [RULE7]
      vecR <= ~strapVectorPin; // [RULE9]
    end else if (regWrite && isRegAddr(regAddr)) begin
      vecR <= regWdata[boot_b_pkg::VEC_BIT]; // wide bit stays; software can't touch it
    end
  end

  // read view; unlisted bits read zero
  always_comb begin
    regView = 32'h0000_0000;
    regView[boot_b_pkg::BASE_MSB:boot_b_pkg::BASE_LSB] = baseR;
    regView[boot_b_pkg::WIDE_BIT] = wideR;
    regView[boot_b_pkg::SIZE_MSB:boot_b_pkg::SIZE_LSB] = sizeR;
    regView[boot_b_pkg::VEC_BIT] = vecR;
    regView[boot_b_pkg::EN_BIT] = enR;
    regView[boot_b_pkg::WE_BIT] = weR;
  end

  // read data one cycle after the strobe, zero elsewhere or unmapped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdataR <= 32'h0000_0000;
    end else if (regRead && isRegAddr(regAddr)) begin
      rdataR <= regView;
    end else begin
      rdataR <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode
  base_decode winCmp (
    .addrHigh(busAddr[31:20]), // [RULE1]
    .baseField(baseR),
    .sizeCode(sizeR), // [RULE2] [RULE8] [RULE14]
    .hit(winHit)
  );

  // vector region: B owns it whenever its bit is set, regardless of A
  assign vecHit = vecR && busAddr[31:20] == boot_b_pkg::VEC_REGION; // [RULE4] [RULE5]
  // blockABootVector only matters to block A; B's claim needs no check of it
  assign hitAny = (enR && winHit) || vecHit; // [RULE10]

  // legal write shapes per width
  always_comb begin
    if (wideR) begin
      writeOk = busSize == boot_b_pkg::XFER_WORD && busAddr[1:0] == 2'h0; // [RULE6] [RULE12]
    end else begin
      writeOk = busSize == boot_b_pkg::XFER_BYTE; // [RULE6] [RULE12]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus answer, registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      selR <= 1'b0;
      ackR <= 1'b0;
      storeR <= 1'b0;
    end else begin
      selR <= busValid && hitAny;
      ackR <= busValid && hitAny && (!busWrite || writeOk); // [RULE12]
      storeR <= busValid && hitAny && busWrite && writeOk && weR; // [RULE11]
    end
  end

  assign regRdata = rdataR;
  assign blockSelect = selR;
  assign termAck = ackR;
  assign storeStrobe = storeR;
  assign wideMode = wideR;
endmodule
`default_nettype wire

/* tb/boot_b_asserts.sv */
`default_nettype none
module boot_b_asserts (
  // watched ports
  input wire logic mclk, rst_n, powerUp, regWrite,
  input wire logic busValid, busWrite, blockSelect, termAck, storeStrobe, wideMode,
  input wire logic [31:0] busAddr,
  input wire logic [2:0] busSize
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // write request qualifier
  wire bw = busValid && busWrite;
  a_ack_has_sel: assert property (termAck |-> blockSelect) else $error("ack without select");
  a_store_has_ack: assert property (storeStrobe |-> termAck) else $error("store no ack");
  a_idle_quiet: assert property (!busValid |=> !blockSelect) else $error("select idle");
  a_byte_on_wide: assert property (bw && busSize == 3'h0 && wideMode |=> !termAck)
    else $error("byte on wide acked");
  a_word_on_narrow: assert property (bw && busSize == 3'h2 && !wideMode |=> !termAck)
    else $error("word on narrow acked");
  a_word_misalign: assert property (bw && busSize == 3'h2 && busAddr[1:0] != 2'h0 |=> !termAck)
    else $error("misaligned acked");
  a_odd_size: assert property (bw && busSize != 3'h0 && busSize != 3'h2 |=> !termAck)
    else $error("odd size acked");
  a_read_term: assert property (busValid && !busWrite |=> termAck == blockSelect && !storeStrobe)
    else $error("read not terminated");
  a_wide_fixed: assert property (regWrite && !powerUp && !$past(powerUp) |=> $stable(wideMode))
    else $error("wide bit moved");
  // main scenarios
  c_store: cover property (storeStrobe);
  c_refused: cover property (blockSelect && !termAck);
  c_no_store: cover property (termAck && !storeStrobe);
endmodule
bind boot_rom_block_b_decoder boot_b_asserts chk (.mclk, .rst_n, .powerUp, .regWrite, .busValid,
  .busWrite, .blockSelect, .termAck, .storeStrobe, .wideMode, .busAddr, .busSize);
`default_nettype wire

/* tb/bus_master.sv */
`default_nettype none
module bus_master (
  // clock
  input wire logic mclk,
  // request
  output logic busValid, busWrite,
  output logic [31:0] busAddr,
  output logic [2:0] busSize
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial begin
    busValid = 1'b0;
    {busWrite, busAddr, busSize} = '0;
  end
  // one-cycle request; released lines flip so stale values never match
  task automatic req(input logic w, input logic [31:0] a, input logic [2:0] s);
    @(posedge mclk);
    busValid <= 1'b1;
    {busWrite, busAddr, busSize} <= {w, a, s};
    @(posedge mclk);
    busValid <= 1'b0;
    {busWrite, busAddr, busSize} <= ~{w, a, s};
  endtask
endmodule
`default_nettype wire

/* tb/boot_rom_block_b_decoder_tb.sv */
`default_nettype none
module boot_rom_block_b_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] A = boot_b_pkg::BASE_SIZE_ADDR;
  logic mclk = 1'b0, rst_n = 1'b0, localReset = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [31:0] regAddr = 32'h0, regWdata = 32'h0;
  wire logic busValid, busWrite, blockSelect, termAck, storeStrobe, wideMode;
  wire logic [31:0] busAddr, regRdata;
  wire logic [2:0] busSize;
  int errors = 0, checks = 0;
  bus_master bm (.mclk, .busValid, .busWrite, .busAddr, .busSize);
  // straps tied: width low gives wide, vector high gives no vector
  boot_rom_block_b_decoder uut (.mclk, .rst_n, .powerUp(1'b0), .localReset, .strapWidthPin(1'b0),
    .strapVectorPin(1'b1), .blockABootVector(1'b1), .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .busValid, .busWrite, .busAddr, .busSize, .blockSelect, .termAck, .storeStrobe,
    .wideMode);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp32(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t reg %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp3(input logic [2:0] got, exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t sel/ack/store %b want %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] d);
    @(posedge mclk);
    {regAddr, regWdata, regWrite} <= {A, d, 1'b1};
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, e);
    @(posedge mclk);
    {regAddr, regRead} <= {a, 1'b1};
    @(posedge mclk);
    regRead <= 1'b0;
    #1 cmp32(regRdata, e);
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [2:0] s, e);
    bm.req(w, a, s);
    #1 cmp3({blockSelect, termAck, storeStrobe}, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(A, 32'hff48_0000);
    rd(A + 32'h4, 32'h0);
    cmp32({31'h0, wideMode}, 32'h1);
  endtask
  task automatic t_window;
    wr(32'h1002_0003);
    rd(A, 32'h100a_0003);
    bus(1'b1, 32'h1030_0000, 3'h2, 3'b111);
    bus(1'b1, 32'h1040_0000, 3'h2, 3'b000);
    bus(1'b1, 32'h1000_0000, 3'h0, 3'b100);
    bus(1'b1, 32'h1000_0002, 3'h2, 3'b100);
    bus(1'b1, 32'h1000_0000, 3'h1, 3'b100);
    wr(32'h1002_0002);
    bus(1'b1, 32'h1000_0004, 3'h2, 3'b110);
    wr(32'h1002_0000);
    bus(1'b0, 32'h1000_0000, 3'h2, 3'b000);
  endtask
  task automatic t_vector;
    wr(32'h1002_0004);
    bus(1'b0, 32'hfff0_0010, 3'h0, 3'b110);
    bus(1'b0, 32'hffe0_0010, 3'h0, 3'b000);
    wr(32'h1002_0000);
    bus(1'b0, 32'hfff0_0010, 3'h0, 3'b000);
  endtask
  task automatic t_size7;
    wr(32'h0c07_0002);
    bus(1'b0, 32'h0ff0_0000, 3'h0, 3'b110);
    bus(1'b0, 32'h1000_0000, 3'h0, 3'b000);
    @(posedge mclk);
    localReset <= 1'b1;
    @(posedge mclk);
    localReset <= 1'b0;
    rd(A, 32'hff48_0000);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // clock, watchdog well past the fewer than 60 cycles needed, main sequence
  initial forever #5 mclk = ~mclk;
  initial begin
    #20us errors++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset();
    t_window();
    t_vector();
    t_size7();
    stop_test();
  end
endmodule
`default_nettype wire
